/* inc/secl_pkg.sv */
package secl_pkg;
  localparam int CLK_HZ = 250_000_000;
  localparam int SCL_HZ = 60_000;
  // quarter period of the serial clock, in core cycles
  localparam int QTR_CYC = CLK_HZ / (SCL_HZ * 4);
  localparam logic [7:0] CSR_OFFSET = 8'hBC;
  localparam int BIT_DL_ERR = 0;
  localparam int BIT_NACK_ERR = 1;
  localparam int BIT_PRESENT = 3;
  localparam int BIT_BUSY = 4;
  localparam int BIT_SW_BUSY = 5;
  localparam int BIT_NO_WADDR = 7;
  localparam logic [6:0] SLAVE_ADDR = 7'h50;
  localparam logic [7:0] FUNC_IND = 8'h00;
  localparam logic [7:0] BYTE_COUNT = 8'h19;
  localparam logic [7:0] END_MARK = 8'h80;
  localparam logic [7:0] LAST_WORD = 8'h1B;
  localparam logic [7:0] FIRST_CFG_WORD = 8'h02;
endpackage

/* design/secl_loader.sv */
`timescale 1ns/1ps
module secl_loader
  import secl_pkg::*;
#(
  parameter int QTR = QTR_CYC
)(
  // clock and resets
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic fund_reset_n,
  input wire logic global_reset_n,
  // configuration register port
  input wire logic cfgWrite,
  input wire logic cfgRead,
  input wire logic [7:0] cfgAddr,
  input wire logic [7:0] cfgWdata,
  output logic [7:0] cfgRdata,
  // software byte access
  input wire logic swStart,
  input wire logic swIsRead,
  input wire logic [7:0] swWordAddr,
  input wire logic [7:0] swData,
  output logic [7:0] swRdata,
  output logic swDone,
  // loaded value stream
  output logic loadValid,
  output logic [7:0] loadCfgAddr,
  output logic [7:0] loadData,
  // system management
  input wire logic [7:0] legacyEvents,
  input wire logic [7:0] legacyEnables,
  output logic sys_mgmt_irq,
  // two-wire pins
  input wire logic sclIn,
  output logic sclOut,
  output logic sclOe_n,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe_n
);
  initial
  begin
    if (QTR < 1)
      $error("QTR must be at least one cycle");
  end

  typedef enum {S_IDLE, S_START, S_BIT, S_ACK, S_RSTART, S_STOP} secl_state_e;
  secl_state_e state;

  logic [1:0] sclSync, sdaSync, fundSync, globSync;
  logic sclPin, sdaPin;
  assign sclPin = sclSync[1];
  assign sdaPin = sdaSync[1];
  logic bothUp, bothUpD;
  assign bothUp = fundSync[1] & globSync[1];

  logic busPresent, nackErr, dlErr, dlBusy, swBusy, noWaddr;
  logic [15:0] qcnt;
  logic [1:0] phase;
  logic tick;
  assign tick = (qcnt == 16'(QTR - 1));
  logic [7:0] shReg, wordPtr, rxByte;
  logic [3:0] bitCnt;
  logic [2:0] seg; // 0 addr-w, 1 word addr, 2 data-w, 3 addr-r, 4 data-r
  logic sclDrvLow, sdaDrvLow, opRead, isDl, nackSeen;

  // first stage feeds only the second
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      sclSync <= 2'h0;
      sdaSync <= 2'h3;
      fundSync <= 2'h0;
      globSync <= 2'h0;
    end
    else
    begin
      sclSync <= {sclSync[0], sclIn};
      sdaSync <= {sdaSync[0], sdaIn};
      fundSync <= {fundSync[0], fund_reset_n};
      globSync <= {globSync[0], global_reset_n};
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      bothUpD <= 1'b0;
    else
      bothUpD <= bothUp;
  end

  // open drain: drive low or release, never high
  assign sclOut = 1'b0;
  assign sdaOut = 1'b0;
  assign sclOe_n = ~sclDrvLow;
  assign sdaOe_n = ~sdaDrvLow;

  function automatic logic [7:0] cfg_target(input logic [7:0] w);
    logic [7:0] r;
    r = 8'h00;
    if (w <= 8'h07)
      r = 8'hD0 + (w - 8'h02);
    else if (w == 8'h08)
      r = 8'hD8;
    else if (w == 8'h09)
      r = 8'hDC;
    else if (w <= 8'h19)
      r = 8'hE0 + (w - 8'h0A);
    else
      r = 8'h61;
    return r;
  endfunction

  function automatic logic [7:0] seg_byte(input logic [2:0] s, input logic [7:0] wa,
                                          input logic [7:0] d);
    logic [7:0] b;
    b = 8'h00;
    case (s)
      3'h0: b = {SLAVE_ADDR, 1'b0};
      3'h1: b = wa;
      3'h2: b = d;
      3'h3: b = {SLAVE_ADDR, 1'b1};
      default: b = 8'hFF;
    endcase
    return b;
  endfunction

  // control/status bits; errors and present flag are sticky
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      busPresent <= 1'b0;
      noWaddr <= 1'b0;
    end
    else if (!globSync[1])
    begin
      busPresent <= 1'b0;
      noWaddr <= 1'b0;
    end
    else if (bothUp && !bothUpD)
      busPresent <= sclPin;
    else if (cfgWrite && cfgAddr == CSR_OFFSET)
    begin
      if (!cfgWdata[BIT_PRESENT])
        busPresent <= 1'b0;
      noWaddr <= cfgWdata[BIT_NO_WADDR];
    end
  end

  // bus engine
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state <= S_IDLE;
      qcnt <= 16'h0;
      phase <= 2'h0;
      sclDrvLow <= 1'b0;
      sdaDrvLow <= 1'b0;
      shReg <= 8'h00;
      bitCnt <= 4'h0;
      seg <= 3'h0;
      opRead <= 1'b0;
      isDl <= 1'b0;
      dlBusy <= 1'b0;
      swBusy <= 1'b0;
      wordPtr <= 8'h00;
      rxByte <= 8'h00;
      nackSeen <= 1'b0;
      dlErr <= 1'b0;
      nackErr <= 1'b0;
      swRdata <= 8'h00;
      swDone <= 1'b0;
      loadValid <= 1'b0;
      loadCfgAddr <= 8'h00;
      loadData <= 8'h00;
    end
    else
    begin
      swDone <= 1'b0;
      loadValid <= 1'b0;
      if (!globSync[1])
      begin
        dlErr <= 1'b0;
        nackErr <= 1'b0;
      end
      else if (cfgWrite && cfgAddr == CSR_OFFSET)
      begin
        // write one clears errors
        if (cfgWdata[BIT_DL_ERR])
          dlErr <= 1'b0;
        if (cfgWdata[BIT_NACK_ERR])
          nackErr <= 1'b0;
      end
      qcnt <= tick ? 16'h0 : qcnt + 16'h1;
      if (!busPresent || !fundSync[1])
      begin
        // disable takes effect immediately and releases both lines
        state <= S_IDLE;
        sclDrvLow <= 1'b0;
        sdaDrvLow <= 1'b0;
        dlBusy <= 1'b0;
        swBusy <= 1'b0;
        isDl <= 1'b0;
        if (!fundSync[1])
        begin
          // a fundamental reset re-arms the one-shot download
          wordPtr <= 8'h00;
          nackSeen <= 1'b0;
        end
      end
      else if (state == S_IDLE)
      begin
        sclDrvLow <= 1'b0;
        sdaDrvLow <= 1'b0;
        if (bothUpD && !isDl && wordPtr == 8'h00 && !dlBusy && !dlErr && seg == 3'h0
            && !nackSeen)
        begin
          // one-shot download after reset
          isDl <= 1'b1;
          dlBusy <= 1'b1;
          opRead <= 1'b1;
          nackSeen <= 1'b1;
          state <= S_START;
          phase <= 2'h0;
          qcnt <= 16'h0;
        end
        else if (swStart && !dlBusy)
        begin
          swBusy <= 1'b1;
          opRead <= swIsRead;
          isDl <= 1'b0;
          wordPtr <= swWordAddr;
          state <= S_START;
          phase <= 2'h0;
          qcnt <= 16'h0;
        end
      end
      else if (tick)
      begin
        phase <= phase + 2'h1;
        case (state)
          S_START:
          begin
            // data falls while clock high, then clock low
            if (phase == 2'h1)
              sdaDrvLow <= 1'b1;
            if (phase == 2'h3)
            begin
              sclDrvLow <= 1'b1;
              seg <= 3'h0;
              shReg <= seg_byte(3'h0, wordPtr, swData);
              bitCnt <= 4'h0;
              state <= S_BIT;
            end
          end
          S_BIT:
          begin
            // phase 0 clock low: change data; 1-2 clock high; 3 fall
            if (phase == 2'h0)
              sdaDrvLow <= (seg == 3'h4) ? 1'b0 : ~shReg[7];
            if (phase == 2'h1)
              sclDrvLow <= 1'b0;
            if (phase == 2'h2)
              rxByte <= {rxByte[6:0], sdaPin};
            if (phase == 2'h3)
            begin
              sclDrvLow <= 1'b1;
              shReg <= {shReg[6:0], 1'b0};
              if (bitCnt == 4'h7)
                state <= S_ACK;
              bitCnt <= bitCnt + 4'h1;
            end
          end
          S_ACK:
          begin
            if (phase == 2'h0)
            begin
              if (seg == 3'h4)
                sdaDrvLow <= isDl && wordPtr != LAST_WORD;
              else
                sdaDrvLow <= 1'b0;
            end
            if (phase == 2'h1)
              sclDrvLow <= 1'b0;
            if (phase == 2'h2 && seg != 3'h4 && sdaPin)
            begin
              nackErr <= 1'b1;
              if (isDl)
                dlErr <= 1'b1;
            end
            if (phase == 2'h3)
            begin
              sclDrvLow <= 1'b1;
              bitCnt <= 4'h0;
              state <= S_BIT;
              if (seg == 3'h0)
                seg <= noWaddr ? (opRead ? 3'h3 : 3'h2) : 3'h1;
              else if (seg == 3'h1)
                seg <= opRead ? 3'h3 : 3'h2;
              else if (seg == 3'h3)
                seg <= 3'h4;
              if (seg == 3'h0 && noWaddr && opRead)
                state <= S_RSTART;
              else if (seg == 3'h1 && opRead)
                state <= S_RSTART;
              else if (seg == 3'h2)
                state <= S_STOP;
              shReg <= seg_byte((seg == 3'h0 && !noWaddr) ? 3'h1 : 3'h2,
                                wordPtr, swData);
              if (seg == 3'h4)
              begin
                if (!isDl)
                begin
                  swRdata <= rxByte;
                  state <= S_STOP;
                end
                else
                begin
                  if ((wordPtr == 8'h00 && rxByte != FUNC_IND) ||
                      (wordPtr == 8'h01 && rxByte != BYTE_COUNT) ||
                      (wordPtr == LAST_WORD && rxByte != END_MARK))
                    dlErr <= 1'b1;
                  if (wordPtr >= FIRST_CFG_WORD && wordPtr < LAST_WORD)
                  begin
                    loadValid <= 1'b1;
                    loadCfgAddr <= cfg_target(wordPtr);
                    loadData <= rxByte;
                  end
                  if (wordPtr == LAST_WORD)
                    state <= S_STOP;
                  wordPtr <= wordPtr + 8'h1;
                end
              end
              // refused byte: pull clock low first so a real stop follows
              if (seg != 3'h4 && sdaPin)
                state <= S_STOP;
            end
          end
          S_RSTART:
          begin
            // release data with clock low, raise clock, then start again
            if (phase == 2'h0)
              sdaDrvLow <= 1'b0;
            if (phase == 2'h1)
              sclDrvLow <= 1'b0;
            if (phase == 2'h2)
              sdaDrvLow <= 1'b1;
            if (phase == 2'h3)
            begin
              sclDrvLow <= 1'b1;
              seg <= 3'h3;
              shReg <= seg_byte(3'h3, wordPtr, swData);
              bitCnt <= 4'h0;
              state <= S_BIT;
            end
          end
          S_STOP:
          begin
            if (phase == 2'h0)
              sdaDrvLow <= 1'b1;
            if (phase == 2'h1)
              sclDrvLow <= 1'b0;
            if (phase == 2'h2)
              sdaDrvLow <= 1'b0;
            if (phase == 2'h3)
            begin
              state <= S_IDLE;
              seg <= 3'h0;
              if (swBusy)
                swDone <= 1'b1;
              swBusy <= 1'b0;
              dlBusy <= 1'b0;
              if (isDl)
                wordPtr <= 8'hFF; // blocks a second download
            end
          end
          default: state <= S_IDLE;
        endcase
      end
    end
  end

  always_comb
  begin
    cfgRdata = 8'h00;
    if (cfgRead && cfgAddr == CSR_OFFSET)
    begin
      cfgRdata[BIT_DL_ERR] = dlErr;
      cfgRdata[BIT_NACK_ERR] = nackErr;
      cfgRdata[BIT_PRESENT] = busPresent;
      cfgRdata[BIT_BUSY] = dlBusy;
      cfgRdata[BIT_SW_BUSY] = swBusy;
      cfgRdata[BIT_NO_WADDR] = noWaddr;
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      sys_mgmt_irq <= 1'b0;
    else
      sys_mgmt_irq <= |(legacyEvents & legacyEnables);
  end
endmodule

/* tb/secl_loader_properties.sv */
`timescale 1ns/1ps
module secl_loader_chk
  import secl_pkg::*;
#(
  parameter int QTR = QTR_CYC
)(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // register and stream side
  input wire logic cfgRead,
  input wire logic [7:0] cfgAddr,
  input wire logic [7:0] cfgRdata,
  input wire logic swDone,
  input wire logic loadValid,
  input wire logic [7:0] loadCfgAddr,
  input wire logic [7:0] legacyEvents,
  input wire logic [7:0] legacyEnables,
  input wire logic sys_mgmt_irq,
  // two-wire pins
  input wire logic sclOut,
  input wire logic sclOe_n,
  input wire logic sdaOut,
  input wire logic sdaOe_n
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  int hiCnt;
  int loCnt;
  // length of the current released and pulled phases of the clock line
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      hiCnt <= 0;
      loCnt <= 0;
    end
    else
    begin
      hiCnt <= sclOe_n ? hiCnt + 1 : 0;
      loCnt <= sclOe_n ? 0 : loCnt + 1;
    end
  end
  drive_low_a: assert property (sclOut == 1'b0 && sdaOut == 1'b0)
    else $error("pin driven high");
  reset_release_a: assert property (disable iff (1'b0) rst |-> sclOe_n && sdaOe_n)
    else $error("pins not released in reset");
  scl_high_a: assert property ($fell(sclOe_n) |-> hiCnt >= 2 * QTR)
    else $error("clock high phase short");
  scl_low_a: assert property ($rose(sclOe_n) |-> loCnt >= 2 * QTR)
    else $error("clock low phase short");
  sda_apart_a: assert property ($changed(sdaOe_n) |-> $stable(sclOe_n))
    else $error("data moved with clock edge");
  done_idle_a: assert property (swDone |=> !swDone && sclOe_n && sdaOe_n)
    else $error("bus not idle after done");
  load_pulse_a: assert property (loadValid |=> !loadValid)
    else $error("load pulse too long");
  load_addr_a: assert property (loadValid |-> loadCfgAddr inside
    {[8'hD0:8'hD5], 8'hD8, 8'hDC, [8'hE0:8'hEF], 8'h61})
    else $error("load target out of map");
  irq_level_a: assert property (sys_mgmt_irq ==
    |($past(legacyEvents) & $past(legacyEnables)))
    else $error("interrupt level wrong");
  rdata_zero_a: assert property (!(cfgRead && cfgAddr == 8'hBC) |-> cfgRdata == 8'h00)
    else $error("read data outside register");
  sw_done_c: cover property (swDone);
  load_c: cover property (loadValid);
  irq_c: cover property ($rose(sys_mgmt_irq));
endmodule
bind secl_loader secl_loader_chk #(.QTR(QTR)) u_secl_loader_chk (.ref_clk(ref_clk),
  .rst(rst), .cfgRead(cfgRead), .cfgAddr(cfgAddr), .cfgRdata(cfgRdata), .swDone(swDone),
  .loadValid(loadValid), .loadCfgAddr(loadCfgAddr), .legacyEvents(legacyEvents),
  .legacyEnables(legacyEnables), .sys_mgmt_irq(sys_mgmt_irq), .sclOut(sclOut),
  .sclOe_n(sclOe_n), .sdaOut(sdaOut), .sdaOe_n(sdaOe_n));

/* tb/secl_eeprom_model.sv */
`timescale 1ns/1ps
module secl_eeprom_model (
  // bus levels
  input wire logic scl,
  input wire logic sda,
  // fault and mode controls
  input wire logic refuseAck,
  input wire logic noWordAddr,
  // open-drain drive, low pulls the line
  output logic sdaPull
);
  logic [7:0] mem [0:255];
  logic [7:0] sh = 8'h00;
  logic [7:0] ptr = 8'h00;
  logic act = 1'b0;
  logic rdPh = 1'b0;
  logic first = 1'b0;
  logic needWa = 1'b0;
  logic sent = 1'b0;
  int bitN = 8;
  initial sdaPull = 1'b1;
  always @(negedge sda)
  begin
    if (scl)
    begin
      act = 1'b1;
      first = 1'b1;
      rdPh = 1'b0;
      sent = 1'b0;
      bitN = 8;
    end
  end
  always @(posedge sda)
  begin
    if (scl)
      act = 1'b0;
  end
  always @(posedge scl)
  begin
    if (act && bitN < 8)
      sh = {sh[6:0], sda};
    else if (act && rdPh && sent)
    begin
      // in a read, only the master's ack slot after a data byte advances the pointer
      sent = 1'b0;
      ptr = ptr + 8'h01;
      // a refused byte ends the read so the stop is not blocked
      act = !sda;
    end
  end
  // changes only after clock falls
  always @(negedge scl)
  begin
    if (act)
    begin
      bitN = (bitN == 8) ? 0 : bitN + 1;
      if (rdPh && bitN < 8)
      begin
        sdaPull = mem[ptr][7 - bitN];
        sent = 1'b1;
      end
      else if (!rdPh && bitN == 8)
      begin
        sdaPull = refuseAck || (first && sh[7:1] != 7'h50);
        if (first)
        begin
          rdPh = sh[0];
          needWa = !sh[0] && !noWordAddr;
          first = 1'b0;
        end
        else if (needWa)
        begin
          ptr = sh;
          needWa = 1'b0;
        end
        else
        begin
          mem[ptr] = sh;
          ptr = ptr + 8'h01;
        end
      end
      else
        sdaPull = 1'b1;
    end
  end
endmodule

/* tb/secl_loader_tb_top.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin checksDone++; if ((g) !== (e)) begin numErrors++; \
  $display("CHECK FAILED t=%0t got %h want %h", $time, g, e); end end
module secl_loader_tb_top
  import secl_pkg::*;
;
  logic ref_clk = 1'b0, rst = 1'b1, fundRst_n = 1'b0, globRst_n = 1'b0;
  logic cfgWrite = 1'b0, cfgRead = 1'b0, swStart = 1'b0, swIsRead = 1'b0;
  logic [7:0] cfgAddr = 8'h00, cfgWdata = 8'h00, swWordAddr = 8'h00, swData = 8'h00;
  logic [7:0] legacyEvents = 8'h00, legacyEnables = 8'h00, cfgRdata, swRdata;
  logic [7:0] loadCfgAddr, loadData, r;
  logic swDone, loadValid, irq, sclOut, sclOe_n, sdaOut, sdaOe_n, sdaPull, ok;
  logic sclPull = 1'b0, refuseAck = 1'b0, noWordAddr = 1'b0;
  logic [7:0] gotA [$];
  logic [7:0] gotD [$];
  int numErrors = 0;
  int checksDone = 0;
  wire scl = sclOe_n ? sclPull : 1'b0;
  wire sda = sdaOe_n & sdaPull;
  always #2 ref_clk = ~ref_clk;
  secl_loader #(.QTR(2)) u_secl_loader (.ref_clk(ref_clk), .rst(rst),
    .fund_reset_n(fundRst_n), .global_reset_n(globRst_n), .cfgWrite(cfgWrite),
    .cfgRead(cfgRead), .cfgAddr(cfgAddr), .cfgWdata(cfgWdata), .cfgRdata(cfgRdata),
    .swStart(swStart), .swIsRead(swIsRead), .swWordAddr(swWordAddr), .swData(swData),
    .swRdata(swRdata), .swDone(swDone), .loadValid(loadValid), .loadCfgAddr(loadCfgAddr),
    .loadData(loadData), .legacyEvents(legacyEvents), .legacyEnables(legacyEnables),
    .sys_mgmt_irq(irq), .sclIn(scl), .sclOut(sclOut), .sclOe_n(sclOe_n), .sdaIn(sda),
    .sdaOut(sdaOut), .sdaOe_n(sdaOe_n));
  secl_eeprom_model u_secl_eeprom_model (.scl(scl), .sda(sda), .refuseAck(refuseAck),
    .noWordAddr(noWordAddr), .sdaPull(sdaPull));
  always @(posedge ref_clk)
  begin
    if (loadValid === 1'b1)
    begin
      gotA.push_back(loadCfgAddr);
      gotD.push_back(loadData);
    end
  end
  function automatic logic [7:0] memv(int k);
    return k == 0 ? 8'h00 : k == 1 ? 8'h19 : k == 27 ? 8'h80 : 8'(k) ^ 8'h5C;
  endfunction
  function automatic logic [7:0] cfgOf(int i);
    return i < 6 ? 8'hD0 + 8'(i) : i == 6 ? 8'hD8 : i == 7 ? 8'hDC :
      i < 24 ? 8'hD8 + 8'(i) : 8'h61;
  endfunction
  task automatic csrWr(input logic [7:0] d);
    @(negedge ref_clk);
    cfgAddr = 8'hBC;
    cfgWdata = d;
    cfgWrite = 1'b1;
    @(negedge ref_clk);
    cfgWrite = 1'b0;
  endtask
  task automatic csrRd();
    @(negedge ref_clk);
    cfgAddr = 8'hBC;
    cfgRead = 1'b1;
    @(posedge ref_clk);
    r = cfgRdata;
    @(negedge ref_clk);
    cfgRead = 1'b0;
  endtask
  task automatic swOp(input logic rd, input logic [7:0] wa, input logic [7:0] d);
    @(negedge ref_clk);
    swIsRead = rd;
    swWordAddr = wa;
    swData = d;
    swStart = 1'b1;
    @(negedge ref_clk);
    swStart = 1'b0;
    ok = 1'b0;
    repeat (1500)
    begin
      @(posedge ref_clk);
      #1;
      if (swDone === 1'b1)
      begin
        ok = 1'b1;
        break;
      end
    end
  endtask
  // fundamental reset released last, so detection follows its edge
  task automatic busRst(input logic pull);
    @(negedge ref_clk);
    sclPull = pull;
    globRst_n = 1'b0;
    fundRst_n = 1'b0;
    gotA.delete();
    gotD.delete();
    repeat (4) @(negedge ref_clk);
    globRst_n = 1'b1;
    repeat (3) @(negedge ref_clk);
    fundRst_n = 1'b1;
    repeat (10) @(negedge ref_clk);
  endtask
  task automatic waitIdle();
    repeat (4000)
    begin
      csrRd();
      if (r[4] === 1'b0)
        break;
    end
  endtask
  task automatic tally_and_finish();
    if (numErrors == 0 && checksDone > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    #100000;
    numErrors++;
    tally_and_finish();
  end
  initial
  begin
    for (int k = 0; k < 256; k++)
      u_secl_eeprom_model.mem[k] = memv(k);
    repeat (2) @(negedge ref_clk);
    rst = 1'b0;
    busRst(1'b0);
    csrRd();
    `CHK(r, 8'h00)
    swOp(1'b1, 8'h30, 8'h00);
    `CHK(ok, 1'b0)
    `CHK(gotA.size(), 0)
    busRst(1'b1);
    csrRd();
    `CHK(r[4:3], 2'b11)
    waitIdle();
    `CHK(r, 8'h08)
    `CHK(gotA.size(), 25)
    for (int i = 0; i < 25; i++)
    begin
      `CHK(gotA[i], cfgOf(i))
      `CHK(gotD[i], memv(i + 2))
    end
    swOp(1'b0, 8'h30, 8'hA5);
    `CHK(ok, 1'b1)
    `CHK(u_secl_eeprom_model.mem[8'h30], 8'hA5)
    swOp(1'b1, 8'h30, 8'h00);
    `CHK(swRdata, 8'hA5)
    csrWr(8'h88);
    noWordAddr = 1'b1;
    swOp(1'b1, 8'h77, 8'h00);
    `CHK(swRdata, memv(8'h31))
    csrWr(8'h08);
    noWordAddr = 1'b0;
    refuseAck = 1'b1;
    swOp(1'b0, 8'h40, 8'h11);
    csrRd();
    `CHK(r[1], 1'b1)
    refuseAck = 1'b0;
    csrWr(8'h0A);
    csrRd();
    `CHK(r, 8'h08)
    for (int i = 0; i < 8; i++)
    begin
      @(negedge ref_clk);
      legacyEvents = 8'h01 << i;
      legacyEnables = i[0] ? 8'hFF : ~legacyEvents;
      repeat (3) @(negedge ref_clk);
      `CHK(irq, i[0])
    end
    legacyEvents = 8'h00;
    u_secl_eeprom_model.mem[0] = 8'h01;
    busRst(1'b1);
    waitIdle();
    `CHK(r[0], 1'b1)
    csrWr(8'h00);
    csrRd();
    `CHK(r[3], 1'b0)
    swOp(1'b0, 8'h30, 8'h5A);
    `CHK(ok, 1'b0)
    tally_and_finish();
  end
endmodule
